// *** rtl/wdrc_pkg.sv ***
// Purpose: Shared constants for the watchdog reset control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Byte offsets are decoded on PADDR[7:0]
package wdrc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFF_TIMER_CTRL      = 8'h04;
    localparam logic [7:0] OFF_COUNT           = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS      = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_OVF_FLAG    = 7;
    localparam int BIT_RST_ENABLE  = 6;
    localparam int BIT_RST_KIND    = 5;
    localparam int BIT_MODE_SELECT = 1;
    localparam int BIT_RUN_ENABLE  = 0;
    localparam int BIT_IRQ_WDOG    = 1;
    localparam int BIT_IRQ_ITVL    = 0;

    // ------------------------------------------------------------
    // Reset values and read patterns
    // ------------------------------------------------------------
    localparam logic [4:0]  UNUSED_READ_ONES = 5'h1F;
    localparam logic [1:0]  IRQ_RESET        = 2'h0;
    localparam logic [7:0]  COUNT_RESET      = 8'h00;
    localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    localparam int COUNT_WIDTH     = 8;
    localparam int PRESCALE_CYCLES = 2;
endpackage

// *** rtl/wdrc_counter.sv ***
// Purpose: Eight-bit watchdog count with a fixed input prescaler
// Assumes: Same clock and reset as the control logic
// Notes:   Overflow is a one-cycle registered pulse
`timescale 1ns/1ns
module wdrc_counter #(
    parameter int WIDTH    = wdrc_pkg::COUNT_WIDTH,
    parameter int PRESCALE = wdrc_pkg::PRESCALE_CYCLES
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             run_enable_in,
    output logic      [WIDTH-1:0] count_out,
    output logic                  overflow_out
);
    localparam int PW = $clog2(PRESCALE + 1);

    logic [PW-1:0]    pre_q;
    logic [PW-1:0]    pre_d;
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic             ovf_q;
    logic             ovf_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (!run_enable_in) begin
            // Held at zero, so a stopped timer can never overflow
            pre_d = '0;
            cnt_d = '0;
        end else if (pre_q == PW'(PRESCALE - 1)) begin
            pre_d = '0;
            cnt_d = cnt_q + 1'b1;
            ovf_d = &cnt_q;
        end else begin
            pre_d = pre_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_q <= '0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign count_out    = cnt_q;
    assign overflow_out = ovf_q;
endmodule

// *** rtl/wdrc_top.sv ***
// Purpose: Watchdog reset control and status with an APB slave
// Assumes: APB master on CLK_IN; one wait-free access phase per request
// Notes:   Internal reset requests are one-cycle pulses for the reset unit
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
module wdrc_top #(
    parameter int PRESCALE = wdrc_pkg::PRESCALE_CYCLES
) (
    input  wire logic        CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             IRQ_OUT,
    output logic             POR_RESET_OUT,
    output logic             MANUAL_RESET_OUT
);
    // ------------------------------------------------------------
    // Watchdog count
    // ------------------------------------------------------------
    logic [wdrc_pkg::COUNT_WIDTH-1:0] watchdog_count;
    logic                             count_overflow;
    logic                             timer_run_enable_q;
    logic                             timer_run_enable_d;
    logic                             timer_mode_select_q;
    logic                             timer_mode_select_d;

    wdrc_counter #(
        .WIDTH    (wdrc_pkg::COUNT_WIDTH),
        .PRESCALE (PRESCALE)
    ) u_counter (
        .clk_in        (CLK_IN),
        .arst_n_in     (ARST_N_IN),
        .run_enable_in (timer_run_enable_q),
        .count_out     (watchdog_count),
        .overflow_out  (count_overflow)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit_rcs;
    logic hit_tc;
    logic hit_cnt;
    logic hit_is;
    logic hit_im;
    logic mapped;

    assign setup   = PSEL_IN && !PENABLE_IN;
    assign access  = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign wr      = access && PWRITE_IN;
    assign rd      = access && !PWRITE_IN;
    assign hit_rcs = PADDR_IN == wdrc_pkg::OFF_RST_CTRL_STATUS;
    assign hit_tc  = PADDR_IN == wdrc_pkg::OFF_TIMER_CTRL;
    assign hit_cnt = PADDR_IN == wdrc_pkg::OFF_COUNT;
    assign hit_is  = PADDR_IN == wdrc_pkg::OFF_IRQ_STATUS;
    assign hit_im  = PADDR_IN == wdrc_pkg::OFF_IRQ_MASK;
    assign mapped  = hit_rcs || hit_tc || hit_cnt || hit_is || hit_im;

    // ------------------------------------------------------------
    // Control and status state
    // ------------------------------------------------------------
    logic       watchdog_overflow_flag_q;
    logic       watchdog_overflow_flag_d;
    logic       clear_armed_q;
    logic       clear_armed_d;
    logic       overflow_reset_enable_q;
    logic       overflow_reset_enable_d;
    logic       reset_kind_select_q;
    logic       reset_kind_select_d;
    logic [1:0] irq_status_q;
    logic [1:0] irq_status_d;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_mask_d;
    logic       por_q;
    logic       por_d;
    logic       man_q;
    logic       man_d;
    logic       irq_q;
    logic       irq_d;
    logic       wdog_event;
    logic       itvl_event;

    // Flag and reset only act in watchdog mode
    assign wdog_event = count_overflow && timer_mode_select_q;
    assign itvl_event = count_overflow && !timer_mode_select_q;

    always_comb begin
        watchdog_overflow_flag_d = watchdog_overflow_flag_q;
        clear_armed_d            = clear_armed_q;
        overflow_reset_enable_d  = overflow_reset_enable_q;
        reset_kind_select_d      = reset_kind_select_q;
        timer_run_enable_d       = timer_run_enable_q;
        timer_mode_select_d      = timer_mode_select_q;
        irq_status_d             = irq_status_q;
        irq_mask_d               = irq_mask_q;
        // Arm the clear only when software has seen the flag set
        if (rd && hit_rcs && watchdog_overflow_flag_q) begin
            clear_armed_d = 1'b1;
        end
        if (wr && hit_rcs) begin
            clear_armed_d           = 1'b0;
            overflow_reset_enable_d = PWDATA_IN[wdrc_pkg::BIT_RST_ENABLE];
            reset_kind_select_d     = PWDATA_IN[wdrc_pkg::BIT_RST_KIND];
            // A one written here is dropped; software cannot set it
            if (clear_armed_q && !PWDATA_IN[wdrc_pkg::BIT_OVF_FLAG]) begin
                watchdog_overflow_flag_d = 1'b0;
            end
        end
        if (wr && hit_tc) begin
            timer_run_enable_d  = PWDATA_IN[wdrc_pkg::BIT_RUN_ENABLE];
            timer_mode_select_d = PWDATA_IN[wdrc_pkg::BIT_MODE_SELECT];
        end
        if (wr && hit_im) begin
            irq_mask_d = PWDATA_IN[1:0];
        end
        if (wr && hit_is) begin
            irq_status_d = irq_status_q & ~PWDATA_IN[1:0];
        end
        // Set wins over a clear in the same cycle
        if (wdog_event) begin
            watchdog_overflow_flag_d = 1'b1;
            irq_status_d[wdrc_pkg::BIT_IRQ_WDOG] = 1'b1;
        end
        if (itvl_event) begin
            irq_status_d[wdrc_pkg::BIT_IRQ_ITVL] = 1'b1;
        end
        irq_d = |(irq_status_d & irq_mask_d);
        por_d = wdog_event && overflow_reset_enable_q
                && !reset_kind_select_q;
        man_d = wdog_event && overflow_reset_enable_q
                && reset_kind_select_q;
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            watchdog_overflow_flag_q <= 1'b0;
            clear_armed_q            <= 1'b0;
            overflow_reset_enable_q  <= 1'b0;
            reset_kind_select_q      <= 1'b0;
            timer_run_enable_q       <= 1'b0;
            timer_mode_select_q      <= 1'b0;
            irq_status_q             <= wdrc_pkg::IRQ_RESET;
            irq_mask_q               <= wdrc_pkg::IRQ_RESET;
            por_q                    <= 1'b0;
            man_q                    <= 1'b0;
            irq_q                    <= 1'b0;
        end else begin
            watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
            clear_armed_q            <= clear_armed_d;
            overflow_reset_enable_q  <= overflow_reset_enable_d;
            reset_kind_select_q      <= reset_kind_select_d;
            timer_run_enable_q       <= timer_run_enable_d;
            timer_mode_select_q      <= timer_mode_select_d;
            irq_status_q             <= irq_status_d;
            irq_mask_q               <= irq_mask_d;
            por_q                    <= por_d;
            man_q                    <= man_d;
            irq_q                    <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;

    // Answer is prepared in setup, so every access phase is one cycle
    always_comb begin
        prdata_d  = wdrc_pkg::DATA_ZERO;
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        if (setup && !PWRITE_IN) begin
            case (PADDR_IN)
                wdrc_pkg::OFF_RST_CTRL_STATUS: begin
                    prdata_d[7:0] = {watchdog_overflow_flag_q,
                                     overflow_reset_enable_q,
                                     reset_kind_select_q,
                                     wdrc_pkg::UNUSED_READ_ONES};
                end
                wdrc_pkg::OFF_TIMER_CTRL: begin
                    prdata_d[1:0] = {timer_mode_select_q,
                                     timer_run_enable_q};
                end
                wdrc_pkg::OFF_COUNT: begin
                    prdata_d[7:0] = watchdog_count;
                end
                wdrc_pkg::OFF_IRQ_STATUS: begin
                    prdata_d[1:0] = irq_status_q;
                end
                wdrc_pkg::OFF_IRQ_MASK: begin
                    prdata_d[1:0] = irq_mask_q;
                end
                default: begin
                    prdata_d = wdrc_pkg::DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            prdata_q  <= wdrc_pkg::DATA_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign PRDATA_OUT       = prdata_q;
    assign PREADY_OUT       = pready_q;
    assign PSLVERR_OUT      = pslverr_q;
    assign IRQ_OUT          = irq_q;
    assign POR_RESET_OUT    = por_q;
    assign MANUAL_RESET_OUT = man_q;
endmodule

// *** test/wdrc_check_sva.sv ***
// Purpose: Port-level checks for the watchdog reset control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Sees only the top module's ports
`timescale 1ns/1ns
module wdrc_check_sva #(
    parameter int PRESCALE = 2
) (
    input wire logic        CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        IRQ_OUT,
    input wire logic        POR_RESET_OUT,
    input wire logic        MANUAL_RESET_OUT
);
    // ------------------------------------------------------------
    // Bus timing and reset request pulses
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    rdy_after_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("ready missing after setup");
    rdy_one_cycle_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    rdy_in_access_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access phase");
    data_idle_zero_a: assert property (!PREADY_OUT |-> PRDATA_OUT == '0)
        else $error("read data not zero while idle");
    unused_ones_a: assert property (
        PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h00 && !PSLVERR_OUT
        |-> PRDATA_OUT[4:0] == 5'h1F && PRDATA_OUT[31:8] == '0)
        else $error("unused status bits wrong");
    por_pulse_a: assert property (POR_RESET_OUT |=> !POR_RESET_OUT)
        else $error("power-on request longer than one cycle");
    man_pulse_a: assert property (MANUAL_RESET_OUT |=> !MANUAL_RESET_OUT)
        else $error("manual request longer than one cycle");
    rst_kind_one_a: assert property (!(POR_RESET_OUT && MANUAL_RESET_OUT))
        else $error("both reset kinds requested");
endmodule
bind wdrc_top wdrc_check_sva #(.PRESCALE(PRESCALE)) i_check (
    .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
    .POR_RESET_OUT(POR_RESET_OUT), .MANUAL_RESET_OUT(MANUAL_RESET_OUT));

// *** test/watchdog_reset_control_tb.sv ***
// Purpose: Self-checking bench for the watchdog reset control block
// Assumes: PRESCALE of 1, so an overflow comes 256 cycles after enable
// Notes:   Bus answers are taken at the rising edge that samples pready
//          Reset request pulses are counted at the falling edge
`timescale 1ns/1ns
module watchdog_reset_control_tb;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        por;
    logic        man;
    logic [31:0] d;
    logic        e;
    int          err_total;
    int          samples_checked;
    int          por_cnt;
    int          man_cnt;

    wdrc_top #(.PRESCALE(1)) i_dut (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .POR_RESET_OUT(por),
        .MANUAL_RESET_OUT(man));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits on pready alone; only the run watchdog ends a silent slave
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Values seen here are those the slave drove before this edge
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(d, exp);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, pulse counting and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (por === 1'b1) por_cnt++;
        if (man === 1'b1) man_cnt++;
    end

    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, samples_checked, por_cnt, man_cnt} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0000_001F);
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        wr(8'h00, 32'h0000_00FF);
        rd(8'h00, 32'h0000_007F);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check({d[31:1], e}, 32'h0000_0001);
        wr(8'h00, 32'h0000_0040);
        wr(8'h10, 32'h0000_0002);
        wr(8'h04, 32'h0000_0001);
        repeat (300) @(posedge clk);
        rd(8'h00, 32'h0000_005F);
        rd(8'h0C, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0003);
        repeat (300) @(posedge clk);
        rd(8'h0C, 32'h0000_0000);
        check(por_cnt + man_cnt, 32'h0000_0000);
        wr(8'h00, 32'h0000_0040);
        wr(8'h04, 32'h0000_0003);
        repeat (300) @(posedge clk);
        wr(8'h04, 32'h0000_0000);
        check(por_cnt, 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        rd(8'h0C, 32'h0000_0002);
        rd(8'h00, 32'h0000_00DF);
        wr(8'h00, 32'h0000_00C0);
        wr(8'h00, 32'h0000_0040);
        rd(8'h00, 32'h0000_00DF);
        wr(8'h00, 32'h0000_0060);
        rd(8'h00, 32'h0000_007F);
        wr(8'h0C, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0000_0000);
        wr(8'h04, 32'h0000_0003);
        repeat (300) @(posedge clk);
        rd(8'h00, 32'h0000_00FF);
        check(man_cnt, 32'h0000_0001);
        check(por_cnt, 32'h0000_0001);
        report_and_stop;
    end
endmodule
